// ### hw/ddsl_loader.v
// serial loader for static and multiplexed display driver chips
`timescale 1ns/1ps
`include "ddsl_consts.vh"
module ddsl_loader #(
  parameter [7:0] PWRUP_BITS = `DDSL_PWRUP_BITS,
  parameter FIFO_DEPTH = `DDSL_FIFO_DEPTH,
  parameter FIFO_AW = `DDSL_FIFO_AW
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire shift_rate_clk_i,
  input wire [7:0] digit_data_i,
  input wire digit_valid_i,
  output wire digit_ready_o,
  input wire [3:0] special_seg_i,
  input wire [3:0] control_code_i,
  input wire frame_mode_i,
  output wire serial_shift_clock_o,
  output wire serial_data_o,
  output wire data_enable_line_n_o,
  output wire mux_select_n_o,
  output wire busy_o,
  output wire init_done_o
);
  localparam [3:0] ST_PWR = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_SEND = 4'h4;
  localparam [3:0] ST_GAP = 4'h8;
  localparam [1:0] STEP_MUX_INIT = 2'h0;
  localparam [1:0] STEP_FLUSH = 2'h1;
  localparam [1:0] STEP_DONE = 2'h2;
  localparam VB = `DDSL_VEC_BITS;

  reg [3:0] state;
  reg [1:0] init_step;
  reg rate_s1;
  reg rate_s2;
  reg rate_q;
  reg gate;
  reg sdata;
  reg enable_n;
  reg mux_sel_n;
  reg [7:0] bit_cnt;
  reg [VB-1:0] shifter;
  reg [31:0] frame_bytes;
  reg [2:0] byte_cnt;
  reg frame_is_update;
  reg [VB-1:0] next_vec;
  reg [7:0] next_len;
  reg next_static_sel;
  wire fall;
  wire have_frame;
  wire start_ok;
  wire pop;
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire [31:0] ser_data;

  ddsl_fifo #(
    .WIDTH(`DDSL_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_data_i(digit_data_i),
    .in_valid_i(digit_valid_i),
    .in_ready_o(digit_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop)
  );

  // byte 0 leads; within a byte the low nibble leads, each nibble msb first
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_order
      assign ser_data[31-8*g -: 8] = {frame_bytes[g*8+3 -: 4], frame_bytes[g*8+7 -: 4]};
    end
  endgenerate

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_s1 <= 1'b0;
      rate_s2 <= 1'b0;
      rate_q <= 1'b0;
    end else begin
      rate_s1 <= shift_rate_clk_i;
      rate_s2 <= rate_s1;
      rate_q <= rate_s2;
    end
  end

  // gate, data, enable and select change only on the falling edge of the rate clock
  assign fall = rate_q & ~rate_s2;
  assign have_frame = (byte_cnt == `DDSL_DIGITS);
  assign start_ok = (init_step != STEP_DONE) | have_frame;
  // fifo drains only while idle, so it backs up during a burst
  assign pop = (state == ST_IDLE) & (init_step == STEP_DONE) & ~have_frame & fifo_valid;

  always @* begin
    next_vec = {VB{1'b0}};
    next_len = `DDSL_FRAME_BITS;
    next_static_sel = 1'b1;
    case (init_step)
      STEP_MUX_INIT: begin
        // four trailing bits form a short block the mux drivers drop
        next_vec = {32'h0000_0000, special_seg_i, control_code_i, 4'h0};
        next_len = `DDSL_MUX_INIT_BITS;
      end
      STEP_FLUSH: begin
        next_vec = {35'h0_0000_0000, 1'b1, 8'h00};
        next_len = `DDSL_FLUSH_BITS;
      end
      default: begin
        if (frame_mode_i) begin
          next_vec = {ser_data, special_seg_i, control_code_i, 4'h0};
          next_len = `DDSL_MUX_FRAME_BITS;
          next_static_sel = 1'b0;
        end else begin
          // trailing start bit arms the static driver for the next frame
          next_vec = {ser_data, 3'h0, 1'b1, 8'h00};
          next_len = `DDSL_FRAME_BITS;
        end
      end
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_PWR;
      init_step <= STEP_MUX_INIT;
      gate <= 1'b1;
      sdata <= 1'b0;
      enable_n <= 1'b0;
      mux_sel_n <= 1'b1;
      bit_cnt <= 8'h00;
      shifter <= {VB{1'b0}};
      frame_bytes <= 32'h0000_0000;
      byte_cnt <= 3'h0;
      frame_is_update <= 1'b0;
    end else begin
      if (pop) begin
        frame_bytes[byte_cnt*8 +: 8] <= fifo_data;
        byte_cnt <= byte_cnt + 3'h1;
      end
      case (state)
        ST_PWR: begin
          // clock free-running with data low clears the static drivers
          if (fall) begin
            if (bit_cnt == PWRUP_BITS - 8'h01) begin
              gate <= 1'b0;
              enable_n <= 1'b1;
              bit_cnt <= 8'h00;
              state <= ST_IDLE;
            end else begin
              bit_cnt <= bit_cnt + 8'h01;
            end
          end
        end
        ST_IDLE: begin
          if (fall && start_ok) begin
            // select falls with the first bit, half a period before its clock edge
            mux_sel_n <= 1'b0;
            enable_n <= ~next_static_sel;
            sdata <= next_vec[VB-1];
            shifter <= {next_vec[VB-2:0], 1'b0};
            bit_cnt <= next_len - 8'h01;
            gate <= 1'b1;
            frame_is_update <= (init_step == STEP_DONE);
          end
          if (fall && start_ok) begin
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (fall) begin
            if (bit_cnt == 8'h00) begin
              gate <= 1'b0;
              sdata <= 1'b0;
              state <= ST_GAP;
            end else begin
              sdata <= shifter[VB-1];
              shifter <= {shifter[VB-2:0], 1'b0};
              bit_cnt <= bit_cnt - 8'h01;
            end
          end
        end
        ST_GAP: begin
          if (fall) begin
            // deselect between writes so the next select edge resets the mux counters
            mux_sel_n <= 1'b1;
            enable_n <= 1'b1;
            if (frame_is_update) begin
              byte_cnt <= 3'h0;
            end
            if (init_step == STEP_MUX_INIT) begin
              init_step <= STEP_FLUSH;
            end else if (init_step == STEP_FLUSH) begin
              init_step <= STEP_DONE;
            end
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // gate only moves while the rate clock is low, so no clock glitches
  assign serial_shift_clock_o = gate & rate_s2;
  assign serial_data_o = sdata;
  assign data_enable_line_n_o = enable_n;
  assign mux_select_n_o = mux_sel_n;
  assign busy_o = (state != ST_IDLE);
  assign init_done_o = (init_step == STEP_DONE);
endmodule

// ### hw/ddsl_consts.vh
// constants for the display driver serial loader
`ifndef DDSL_CONSTS_VH
`define DDSL_CONSTS_VH
// zero bits clocked out after reset, well above the 36 needed
`define DDSL_PWRUP_BITS 8'h40
// multiplexed-driver initialisation transfer length
`define DDSL_MUX_INIT_BITS 8'h2C
// flush: 35 zeros plus one start bit
`define DDSL_FLUSH_BITS 8'h24
// universal update: 32 data, 3 zeros, 1 start bit
`define DDSL_FRAME_BITS 8'h24
// multiplexed-only update: 32 data, special nibble, control nibble
`define DDSL_MUX_FRAME_BITS 8'h28
// shift vector width, long enough for the longest transfer
`define DDSL_VEC_BITS 44
// digit bytes per update
`define DDSL_DIGITS 3'h4
// fifo shape
`define DDSL_FIFO_WIDTH 8
`define DDSL_FIFO_DEPTH 8
`define DDSL_FIFO_AW 3
`endif

// ### hw/ddsl_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ddsl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### tb/ddsl_assertions.sv
// checker for the loader's serial link
`timescale 1ns/1ps
module ddsl_chk (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire serial_shift_clock_o,
  input wire serial_data_o,
  input wire data_enable_line_n_o,
  input wire mux_select_n_o,
  input wire busy_o,
  input wire init_done_o
);
  wire k = serial_shift_clock_o;
  wire d = serial_data_o;
  wire en = data_enable_line_n_o;
  wire se = mux_select_n_o;
  wire ok = init_done_o;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_idle_levels: assert property (!busy_o |-> en && se && !d && !k)
    else $error("idle levels wrong");
  a_data_change: assert property ($changed(d) |-> !k)
    else $error("data moved while clock high");
  a_stop_first: assert property ($rose(se) |-> !k && !$past(k, 4))
    else $error("deselect with clock running");
  a_sel_gap: assert property ($rose(se) |=> se [*4])
    else $error("select gap too short");
  a_busy_sel: assert property (!se |-> busy_o)
    else $error("select low while idle");
  a_init_hold: assert property (ok |=> ok)
    else $error("init done dropped");
  a_pwrup_zeros: assert property (!ok && se |-> !d)
    else $error("data high before init");
  a_en_pair: assert property (ok && !en |-> !se)
    else $error("enable low without select");
  c_mux: cover property ($fell(se) && en);
  c_uni: cover property ($fell(en) && ok);
  c_init: cover property ($rose(ok));
endmodule
bind ddsl_loader ddsl_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .serial_shift_clock_o(serial_shift_clock_o),
  .serial_data_o(serial_data_o), .data_enable_line_n_o(data_enable_line_n_o), .mux_select_n_o(mux_select_n_o),
  .busy_o(busy_o), .init_done_o(init_done_o));

// ### tb/ddsl_drv_model.sv
// listener standing for the serial display driver chips
`timescale 1ns/1ps
module ddsl_drv_model (
  input wire sck_i,
  input wire sdata_i,
  input wire en_n_i,
  input wire sel_n_i,
  output reg [7:0] nbits_o,
  output reg [63:0] vec_o,
  output reg en_seen_o,
  output reg sel_seen_o,
  output integer frames_o
);
  reg [7:0] cnt = 8'h00;
  reg [63:0] sh = 64'h0;
  reg e = 1'b0;
  reg s = 1'b0;
  wire idle = en_n_i & sel_n_i;
  initial frames_o = 0;
  // select fall clears counters
  always @(negedge sel_n_i) begin
    cnt = 8'h00;
    sh = 64'h0;
  end
  // enable only gates bits, never clears
  always @(posedge sck_i) if (!en_n_i || !sel_n_i) begin
    sh = {sh[62:0], sdata_i};
    cnt = cnt + 8'h01;
    e = e | !en_n_i;
    s = s | !sel_n_i;
  end
  // one log entry each time enable and select are both high again
  always @(posedge idle) begin
    nbits_o = cnt;
    vec_o = sh;
    en_seen_o = e;
    sel_seen_o = s;
    e = 1'b0;
    s = 1'b0;
    frames_o = frames_o + 1;
  end
endmodule

// ### tb/tb.sv
// testbench for the display driver serial loader
`timescale 1ns/1ps
module tb;
  reg clk_sys_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg rate = 1'b0;
  reg [7:0] dd = 8'h00;
  reg dv = 1'b0;
  reg [3:0] sp = 4'hA;
  reg [3:0] cc = 4'h5;
  reg fm = 1'b0;
  reg [7:0] bt [0:8];
  wire sck, sd, en_n, sel_n, busy, idone, rdy, es, ss;
  wire [7:0] nb;
  wire [63:0] vec;
  integer fr;
  integer failures = 0;
  integer checks_done = 0;
  integer i;
  always #50 clk_sys_i = ~clk_sys_i;
  always #400 rate = ~rate;
  // shorter power-up run, still above 36
  ddsl_loader #(.PWRUP_BITS(8'h28)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .shift_rate_clk_i(rate),
    .digit_data_i(dd), .digit_valid_i(dv), .digit_ready_o(rdy), .special_seg_i(sp), .control_code_i(cc),
    .frame_mode_i(fm), .serial_shift_clock_o(sck), .serial_data_o(sd), .data_enable_line_n_o(en_n),
    .mux_select_n_o(sel_n), .busy_o(busy), .init_done_o(idone));
  ddsl_drv_model PM (.sck_i(sck), .sdata_i(sd), .en_n_i(en_n), .sel_n_i(sel_n), .nbits_o(nb), .vec_o(vec),
    .en_seen_o(es), .sel_seen_o(ss), .frames_o(fr));
  task chk(input [63:0] seen, input [63:0] exp, input string what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task wait_frame;
    integer n;
    integer f0;
    begin
      f0 = fr;
      n = 0;
      while (fr == f0 && n < 3000) begin
        @(negedge clk_sys_i);
        n = n + 1;
      end
      if (n == 3000) failures = failures + 1;
    end
  endtask
  task push(input [7:0] b);
    integer n;
    begin
      @(negedge clk_sys_i);
      dd = b;
      dv = 1'b1;
      n = 0;
      while (rdy !== 1'b1 && n < 3000) begin
        @(negedge clk_sys_i);
        n = n + 1;
      end
      if (n == 3000) failures = failures + 1;
      @(posedge clk_sys_i);
    end
  endtask
  // wire image of four bytes, low nibble first
  function [31:0] ev(input integer k);
    integer j;
    begin
      ev = 32'h0;
      for (j = 0; j < 4; j = j + 1) ev = {ev[23:0], bt[k+j][3:0], bt[k+j][7:4]};
    end
  endfunction
  // fifo fills during power-up, ninth byte refused
  task t_fill;
    begin
      for (i = 0; i < 8; i = i + 1) push(bt[i]);
      @(negedge clk_sys_i);
      dd = bt[8];
      chk(rdy, 1'b0, "ready");
      @(negedge clk_sys_i);
      dv = 1'b0;
    end
  endtask
  task t_pwrup;
    begin
      wait_frame;
      chk({es, ss}, 2'b10, "lines");
      chk(nb > 8'd36, 1'b1, "zeros");
      chk(vec, 64'h0, "data");
    end
  endtask
  task t_init;
    begin
      wait_frame;
      chk(nb, 8'd44, "bits");
      chk(vec[43:0], {32'h0, sp, cc, 4'h0}, "data");
      chk({es, ss}, 2'b11, "lines");
      chk(nb[2:0], 3'h4, "short tail");
    end
  endtask
  task t_flush;
    begin
      wait_frame;
      chk(nb, 8'd36, "bits");
      chk(vec[35:0], 36'h1, "data");
      chk(idone, 1'b1, "done");
    end
  endtask
  task t_uni(input integer k);
    begin
      wait_frame;
      chk(nb, 8'd36, "bits");
      chk(vec[0], 1'h1, "next start");
      chk(vec[35:0], {ev(k), 4'h1}, "data");
      chk({es, ss}, 2'b11, "lines");
    end
  endtask
  // mux-only frame; static enable stays high
  task t_mux;
    begin
      chk(rdy, 1'b1, "drained");
      @(negedge clk_sys_i);
      fm = 1'b1;
      for (i = 0; i < 4; i = i + 1) push(bt[i]);
      @(negedge clk_sys_i);
      dv = 1'b0;
      wait_frame;
      chk(nb, 8'd40, "bits");
      chk(vec[39:0], {ev(0), sp, cc}, "data");
      chk({es, ss}, 2'b01, "lines");
      chk(nb[2:0], 3'h0, "whole blocks");
      repeat (16) @(negedge clk_sys_i);
      chk(busy, 1'b0, "busy");
    end
  endtask
  initial begin
    for (i = 0; i < 9; i = i + 1) bt[i] = 8'h2C + 8'h13 * i[7:0];
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_fill;
    t_pwrup;
    t_init;
    t_flush;
    t_uni(0);
    t_uni(4);
    t_mux;
    end_sim;
  end
  // about 2000 cycles expected
  initial begin
    #1000000;
    failures = failures + 1;
    end_sim;
  end
endmodule
